/* File: src/eep_pkg.sv */
// shared constants and types for the two-wire eeprom slave
package eep_pkg;
    // slave address layout
    localparam logic [3:0] EEP_DEV_CODE = 4'ha;
    localparam int EEP_CODE_MSB = 7;
    localparam int EEP_CODE_LSB = 4;
    localparam int EEP_CS_BIT = 3;
    localparam int EEP_BLK_MSB = 2;
    localparam int EEP_BLK_LSB = 1;
    localparam int EEP_RW_BIT = 0;

    // memory geometry
    localparam int EEP_ADDR_W = 10;
    localparam int EEP_PAGE_W = 4;
    localparam int EEP_PAGE_N = 16;
    localparam int EEP_BITS_PER_BYTE = 8;

    // self-timed programming cycle
    localparam int EEP_TWR_MS = 10;
    localparam int EEP_CLK_HZ = 40_000_000;
    localparam int EEP_TWR_CYCLES = EEP_TWR_MS * (EEP_CLK_HZ / 1000);

    // reset values
    localparam logic [EEP_ADDR_W-1:0] EEP_ADDR_RST = 10'h000;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEV,
        ST_WORD,
        ST_DATA,
        ST_TX,
        ST_MACK
    } eep_state_e;

    // bus conditions seen on the synchronised lines
    typedef struct packed {
        logic start;
        logic stop;
        logic rise;
        logic fall;
        logic sda;
    } eep_bus_ev_s;
endpackage

/* File: src/eep_prog_timer.sv */
// self-timed programming cycle, runs on the system clock
module eep_prog_timer
    import eep_pkg::*;
#(
    parameter int TWR_CYC = EEP_TWR_CYCLES
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // request toggle from the link domain, completion toggle back
    input wire logic i_req_tgl,
    output logic o_done_tgl,
    output logic o_busy
);
    localparam int CW = $clog2(TWR_CYC + 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(TWR_CYC - 1);

    logic req_s;
    logic seen_q, seen_d;
    logic done_q, done_d;
    logic busy_q, busy_d;
    logic [CW-1:0] cnt_q, cnt_d;

    eep_sync #(.W(1)) u_req_sync (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_async(i_req_tgl),
        .o_sync(req_s)
    );

    always_comb begin
        seen_d = seen_q;
        done_d = done_q;
        busy_d = busy_q;
        cnt_d = cnt_q;
        if (busy_q) begin
            if (cnt_q == CNT_LAST) begin
                busy_d = 1'b0;
                done_d = seen_q;
            end else begin
                cnt_d = cnt_q + CW'(1);
            end
        end else if (req_s != seen_q) begin
            seen_d = req_s;
            busy_d = 1'b1;
            cnt_d = '0;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            seen_q <= 1'b0;
            done_q <= 1'b0;
            busy_q <= 1'b0;
            cnt_q <= '0;
        end else begin
            seen_q <= seen_d;
            done_q <= done_d;
            busy_q <= busy_d;
            cnt_q <= cnt_d;
        end
    end

    assign o_done_tgl = done_q;
    assign o_busy = busy_q;
endmodule

/* File: src/eep_sync.sv */
// two flip-flop level synchroniser, one per bit
module eep_sync
    import eep_pkg::*;
#(
    parameter int W = 1
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // levels
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    for (genvar g = 0; g < W; g++) begin : g_bit
        always_ff @(posedge i_clk or posedge i_reset) begin
            if (i_reset) begin
                meta_q[g] <= 1'b0;
                sync_q[g] <= 1'b0;
            end else begin
                meta_q[g] <= i_async[g];
                sync_q[g] <= meta_q[g];
            end
        end
    end

    assign o_sync = sync_q;
endmodule

/* File: src/eep_top.sv */
// two-wire serial eeprom slave: polling, write protect, read modes
// Contract
// - no slave-address acknowledge while write cycle runs
// - stop after write starts timed programming
// - acknowledge control byte once programming finished
// - protect pin high never alters memory
// - protected: ack addresses, not first data byte
// - protected attempt starts no programming at stop
// - read is write header with direction one
// - counter holds last accessed address plus one; a write to a page's last byte leaves it at that page's first byte
// - read address acked, byte sent msb first
// - repeated start aborts write, pointer stays loaded
// - each master acknowledge sends next byte
// - sequential read wraps at top, continues
// - address byte: code 1010, selects, direction
// - two low selects pick block; top compared
// - byte after write address loads pointer
module eep_top
    import eep_pkg::*;
#(
    parameter int TWR_CYC = EEP_TWR_CYCLES,
    parameter int ADDR_W = EEP_ADDR_W
) (
    // system clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // link sampling clock
    input wire logic i_link_clk,
    // two-wire bus
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda,
    output logic o_sda_oe,
    // straps
    input wire logic i_wp,
    input wire logic i_chip_select_input,
    // status
    output logic o_busy
);
    localparam int DEPTH = 1 << ADDR_W;
    localparam logic [3:0] BYTE_DONE = 4'(EEP_BITS_PER_BYTE);

    // synchronised pins: scl, sda, wp, chip select, completion toggle
    logic [4:0] pins_s;
    logic scl_s, sda_s, wp_s, cs_s, done_s;
    logic done_tgl;

    eep_sync #(.W(5)) u_pin_sync (
        .i_clk(i_link_clk),
        .i_reset(i_reset),
        .i_async({i_scl, i_sda, i_wp, i_chip_select_input, done_tgl}),
        .o_sync(pins_s)
    );
    assign {scl_s, sda_s, wp_s, cs_s, done_s} = pins_s;

    // link-domain state
    eep_state_e st_q, st_d;
    logic scl_p_q, sda_p_q;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] sh_q, sh_d;
    logic [7:0] tx_q, tx_d;
    logic ack_q, ack_d;
    logic rw_q, rw_d;
    logic [1:0] blk_q, blk_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [EEP_PAGE_N-1:0] mask_q, mask_d;
    logic oe_q, oe_d;
    logic sda_o_q;
    logic tgl_q, tgl_d;
    logic commit;
    logic buf_we;
    logic busy;
    logic [7:0] rd_byte;
    eep_bus_ev_s ev;

    logic [7:0] mem [DEPTH];
    logic [7:0] pbuf [EEP_PAGE_N];

    assign rd_byte = mem[addr_q];
    // write cycle runs while the request has not come back
    assign busy = tgl_q != done_s;

    // control byte fields
    logic ctl_hit;
    logic ctl_rd;
    logic [1:0] ctl_blk;
    assign ctl_hit = (sh_q[EEP_CODE_MSB:EEP_CODE_LSB] == EEP_DEV_CODE) &&
                     (sh_q[EEP_CS_BIT] == cs_s);
    assign ctl_rd = sh_q[EEP_RW_BIT];
    assign ctl_blk = sh_q[EEP_BLK_MSB:EEP_BLK_LSB];

    // eight bits have passed since the last acknowledge
    logic byte_full;
    assign byte_full = cnt_q == BYTE_DONE;

    // next write slot: low bits roll over inside the page, upper bits hold
    logic [ADDR_W-1:0] page_next;
    assign page_next = {addr_q[ADDR_W-1:EEP_PAGE_W], addr_q[EEP_PAGE_W-1:0] + 4'h1};

    // drive for the bit now going out, msb first
    logic tx_low;
    assign tx_low = ~tx_q[3'(4'h7 - cnt_q)];

    always_comb begin
        ev.start = scl_s & scl_p_q & sda_p_q & ~sda_s;
        ev.stop = scl_s & scl_p_q & ~sda_p_q & sda_s;
        ev.rise = scl_s & ~scl_p_q;
        ev.fall = ~scl_s & scl_p_q;
        ev.sda = sda_s;
    end

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        tx_d = tx_q;
        ack_d = ack_q;
        rw_d = rw_q;
        blk_d = blk_q;
        addr_d = addr_q;
        mask_d = mask_q;
        oe_d = oe_q;
        tgl_d = tgl_q;
        commit = 1'b0;
        buf_we = 1'b0;
        if (ev.start) begin
            // repeated start drops buffered data; pointer is kept
            st_d = ST_DEV;
            cnt_d = '0;
            ack_d = 1'b0;
            oe_d = 1'b0;
            mask_d = '0;
        end else if (ev.stop) begin
            // program only real, unprotected data
            if (st_q == ST_DATA && mask_q != '0 && !wp_s && !busy) begin
                commit = 1'b1;
                tgl_d = ~tgl_q;
            end
            st_d = ST_IDLE;
            ack_d = 1'b0;
            oe_d = 1'b0;
            mask_d = '0;
        end else begin
            unique case (st_q)
                ST_IDLE: begin
                end
                ST_DEV, ST_WORD, ST_DATA: begin
                    if (ev.rise && !ack_q) begin
                        sh_d = {sh_q[6:0], ev.sda};
                        cnt_d = cnt_q + 4'h1;
                    end else if (ev.fall && !ack_q && byte_full) begin
                        unique case (st_q)
                            ST_DEV: begin
                                // code, top select, idle
                                if (ctl_hit && !busy) begin
                                    ack_d = 1'b1;
                                    oe_d = 1'b1;
                                    blk_d = ctl_blk;
                                    rw_d = ctl_rd;
                                end else begin
                                    st_d = ST_IDLE;
                                end
                            end
                            ST_WORD: begin
                                // block bits join the word address
                                ack_d = 1'b1;
                                oe_d = 1'b1;
                                addr_d = {blk_q, sh_q};
                                mask_d = '0;
                            end
                            default: begin
                                if (wp_s) begin
                                    st_d = ST_IDLE;
                                end else begin
                                    ack_d = 1'b1;
                                    oe_d = 1'b1;
                                    buf_we = 1'b1;
                                    mask_d[addr_q[EEP_PAGE_W-1:0]] = 1'b1;
                                    // counter follows the last written byte
                                    addr_d = page_next;
                                end
                            end
                        endcase
                    end else if (ev.fall && ack_q) begin
                        ack_d = 1'b0;
                        oe_d = 1'b0;
                        cnt_d = '0;
                        if (st_q == ST_DEV && rw_q) begin
                            // first read byte, msb first
                            st_d = ST_TX;
                            tx_d = rd_byte;
                            oe_d = ~rd_byte[7];
                        end else if (st_q == ST_DEV) begin
                            st_d = ST_WORD;
                        end else begin
                            st_d = ST_DATA;
                        end
                    end
                end
                ST_TX: begin
                    if (ev.rise) begin
                        cnt_d = cnt_q + 4'h1;
                    end else if (ev.fall) begin
                        if (byte_full) begin
                            // release for the master's acknowledge; wraps
                            oe_d = 1'b0;
                            st_d = ST_MACK;
                            addr_d = addr_q + ADDR_W'(1);
                        end else begin
                            oe_d = tx_low;
                        end
                    end
                end
                ST_MACK: begin
                    if (ev.rise) begin
                        sh_d = {sh_q[6:0], ev.sda};
                    end else if (ev.fall) begin
                        cnt_d = '0;
                        if (!sh_q[0]) begin
                            // acknowledged: next byte, across the top
                            st_d = ST_TX;
                            tx_d = rd_byte;
                            oe_d = ~rd_byte[7];
                        end else begin
                            // no acknowledge: line stays released
                            st_d = ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_link_clk or posedge i_reset) begin
        if (i_reset) begin
            st_q <= ST_IDLE;
            scl_p_q <= 1'b0;
            sda_p_q <= 1'b0;
            cnt_q <= '0;
            sh_q <= '0;
            tx_q <= '0;
            ack_q <= 1'b0;
            rw_q <= 1'b0;
            blk_q <= '0;
            addr_q <= ADDR_W'(EEP_ADDR_RST);
            mask_q <= '0;
            oe_q <= 1'b0;
            sda_o_q <= 1'b0;
            tgl_q <= 1'b0;
        end else begin
            st_q <= st_d;
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            tx_q <= tx_d;
            ack_q <= ack_d;
            rw_q <= rw_d;
            blk_q <= blk_d;
            addr_q <= addr_d;
            mask_q <= mask_d;
            oe_q <= oe_d;
            sda_o_q <= 1'b0;
            tgl_q <= tgl_d;
        end
    end

    // page buffer holds data until the stop
    always_ff @(posedge i_link_clk) begin
        if (buf_we) begin
            pbuf[addr_q[EEP_PAGE_W-1:0]] <= sh_q;
        end
    end

    // array write at the start of the timed cycle
    always_ff @(posedge i_link_clk) begin
        if (commit) begin
            for (int i = 0; i < EEP_PAGE_N; i++) begin
                if (mask_q[i]) begin
                    mem[{addr_q[ADDR_W-1:EEP_PAGE_W], 4'(i)}] <= pbuf[i];
                end
            end
        end
    end

    eep_prog_timer #(.TWR_CYC(TWR_CYC)) u_timer (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_req_tgl(tgl_q),
        .o_done_tgl(done_tgl),
        .o_busy(o_busy)
    );

    assign o_sda = sda_o_q;
    assign o_sda_oe = oe_q;
endmodule

/* File: verif/eep_checker.sv */
// pin-level assertions for the eeprom slave
module eep_checker
    import eep_pkg::*;
#(
    parameter int TWR_CYC = EEP_TWR_CYCLES
) (
    // clocks and reset
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_link_clk,
    // bus and straps
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic i_wp,
    input wire logic i_chip_select_input,
    // device outputs
    input wire logic o_sda,
    input wire logic o_sda_oe,
    input wire logic o_busy
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] busy_cnt_q;
    logic [31:0] busy_cnt_d;
    always_comb begin
        busy_cnt_d = o_busy ? busy_cnt_q + 32'h0000_0001 : 32'h0000_0000;
    end
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            busy_cnt_q <= 32'h0000_0000;
        end else begin
            busy_cnt_q <= busy_cnt_d;
        end
    end
    busy_quiet_a: assert property (@(posedge i_clk) disable iff (i_reset)
        o_busy |-> !o_sda_oe) else $error("bus driven while busy");
    prog_len_a: assert property (@(posedge i_clk) disable iff (i_reset)
        $fell(o_busy) |-> busy_cnt_q == TWR_CYC) else $error("programming length");
    prog_cause_a: assert property (@(posedge i_clk) disable iff (i_reset)
        $rose(o_busy) |-> i_scl && i_sda) else $error("programming not after stop");
    wp_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
        $rose(o_busy) |-> !$past(i_wp, 2)) else $error("programming while protected");
    oe_edge_a: assert property (@(posedge i_link_clk) disable iff (i_reset)
        $changed(o_sda_oe) |-> !i_scl) else $error("drive changed with clock high");
    free_cond_a: assert property (@(posedge i_clk) disable iff (i_reset)
        i_scl && $changed(i_sda) |-> !o_sda_oe) else $error("driving at start or stop");
    low_only_a: assert property (@(posedge i_link_clk) disable iff (i_reset)
        !o_sda) else $error("data output not low");
    reset_idle_a: assert property (@(posedge i_clk) disable iff (i_reset)
        $fell(i_reset) |-> !o_sda_oe && !o_busy) else $error("not idle after reset");
    cover property (@(posedge i_clk) $rose(o_busy));
    cover property (@(posedge i_link_clk) $rose(o_sda_oe));
    cover property (@(posedge i_clk) i_wp && i_scl && $rose(i_sda));
endmodule

bind eep_top eep_checker #(.TWR_CYC(TWR_CYC)) eep_checker_inst (.i_clk(i_clk),
    .i_reset(i_reset), .i_link_clk(i_link_clk), .i_scl(i_scl), .i_sda(i_sda), .i_wp(i_wp),
    .i_chip_select_input(i_chip_select_input), .o_sda(o_sda), .o_sda_oe(o_sda_oe),
    .o_busy(o_busy));

/* File: verif/eep_master.sv */
// two-wire bus master model: drives the clock, pulls data low
module eep_master (
    // clock
    input wire logic i_clk,
    // bus
    input wire logic i_sda,
    output logic o_scl = 1'b1,
    output logic o_pull = 1'b0
);
    timeunit 1ns;
    timeprecision 100ps;
    task automatic hp(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    // also a repeated start; leaves the clock low
    task automatic start();
        hp(4);
        o_pull = 1'b0;
        hp(48);
        o_scl = 1'b1;
        hp(48);
        o_pull = 1'b1;
        hp(48);
        o_scl = 1'b0;
    endtask
    task automatic stop();
        hp(4);
        o_pull = 1'b1;
        hp(48);
        o_scl = 1'b1;
        hp(48);
        o_pull = 1'b0;
        hp(48);
    endtask
    // nine bits msb first; data moves a little after the clock falls
    task automatic xfer(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) begin
            hp(4);
            o_pull = ~d[i];
            hp(44);
            o_scl = 1'b1;
            hp(24);
            q[i] = i_sda;
            hp(24);
            o_scl = 1'b0;
        end
    endtask
endmodule

/* File: verif/tb_top.sv */
// self-checking bench for the eeprom slave
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int TWR = 2000;
    logic i_clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst = 1'b1;
    logic wp = 1'b0;
    logic cs = 1'b1;
    logic scl;
    logic pull;
    logic sda_oe;
    logic busy;
    wire logic sda;
    int n_mismatch = 0;
    int n_tests = 0;
    assign sda = ~(sda_oe | pull);
    always #12.5 i_clk = ~i_clk;
    initial begin
        #7;
        forever #40 link_clk = ~link_clk;
    end
    eep_top #(.TWR_CYC(TWR)) eep_top_inst (.i_clk(i_clk), .i_reset(rst),
        .i_link_clk(link_clk), .i_scl(scl), .i_sda(sda), .o_sda(), .o_sda_oe(sda_oe),
        .i_wp(wp), .i_chip_select_input(cs), .o_busy(busy));
    eep_master eep_master_inst (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_pull(pull));
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic close_out();
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    function automatic logic [8:0] cb(input logic [9:0] a, input logic rw);
        return {4'ha, cs, a[9:8], rw, 1'b1};
    endfunction
    task automatic wr(input logic [9:0] a, input logic [7:0] d, output logic [2:0] k);
        logic [8:0] q;
        eep_master_inst.start();
        eep_master_inst.xfer(cb(a, 1'b0), q);
        k[2] = q[0];
        eep_master_inst.xfer({a[7:0], 1'b1}, q);
        k[1] = q[0];
        eep_master_inst.xfer({d, 1'b1}, q);
        k[0] = q[0];
        eep_master_inst.stop();
    endtask
    task automatic poll(output int n);
        logic [8:0] q;
        n = 0;
        do begin
            eep_master_inst.start();
            eep_master_inst.xfer(cb(10'h000, 1'b0), q);
            eep_master_inst.stop();
            n++;
        end while (q[0] !== 1'b0 && n < 12);
    endtask
    // word address, repeated start, one byte read
    task automatic rd1(input logic [9:0] a, output logic [7:0] b);
        logic [8:0] q;
        eep_master_inst.start();
        eep_master_inst.xfer(cb(a, 1'b0), q);
        eep_master_inst.xfer({a[7:0], 1'b1}, q);
        eep_master_inst.start();
        eep_master_inst.xfer(cb(a, 1'b1), q);
        eep_master_inst.xfer({8'hff, 1'b1}, q);
        b = q[8:1];
        eep_master_inst.stop();
    endtask
    task automatic t_write_poll();
        logic [2:0] k;
        int n;
        wr(10'h000, 8'h5a, k);
        chk("wr_ack", {5'h00, k}, 8'h00);
        poll(n);
        chk("poll_busy", {7'h00, n > 1}, 8'h01);
        chk("poll_done", {7'h00, n < 12}, 8'h01);
        wr(10'h3ff, 8'ha5, k);
        poll(n);
        wr(10'h3fe, 8'hc3, k);
        chk("busy", {7'h00, busy}, 8'h01);
        poll(n);
    endtask
    task automatic t_seq_read();
        logic [8:0] q;
        eep_master_inst.start();
        eep_master_inst.xfer(cb(10'h000, 1'b1), q);
        chk("rd_ack", {7'h00, q[0]}, 8'h00);
        eep_master_inst.xfer({8'hff, 1'b0}, q);
        chk("cur_byte", q[8:1], 8'ha5);
        eep_master_inst.xfer({8'hff, 1'b1}, q);
        chk("wrap_byte", q[8:1], 8'h5a);
        eep_master_inst.stop();
        chk("released", {7'h00, sda}, 8'h01);
    endtask
    task automatic t_random();
        logic [7:0] b;
        logic [8:0] q;
        rd1(10'h3fe, b);
        chk("rand_byte", b, 8'hc3);
        repeat (80) @(negedge i_clk);
        chk("no_prog", {7'h00, busy}, 8'h00);
        // buffered data byte, then repeated start: nothing may be programmed
        eep_master_inst.start();
        eep_master_inst.xfer(cb(10'h3fe, 1'b0), q);
        eep_master_inst.xfer({8'hfe, 1'b1}, q);
        eep_master_inst.xfer({8'h11, 1'b1}, q);
        eep_master_inst.start();
        eep_master_inst.xfer(cb(10'h000, 1'b1), q);
        eep_master_inst.xfer({8'hff, 1'b1}, q);
        chk("abort_cur", q[8:1], 8'ha5);
        eep_master_inst.stop();
        repeat (80) @(negedge i_clk);
        chk("abort_prog", {7'h00, busy}, 8'h00);
    endtask
    task automatic t_protect();
        logic [2:0] k;
        logic [7:0] b;
        wp = 1'b1;
        wr(10'h3fe, 8'h00, k);
        chk("wp_acks", {5'h00, k}, 8'h01);
        chk("wp_idle", {7'h00, busy}, 8'h00);
        rd1(10'h3fe, b);
        wp = 1'b0;
        chk("wp_keep", b, 8'hc3);
    endtask
    task automatic t_reject();
        logic [8:0] q;
        logic [8:0] bad [2];
        bad = '{{4'ha, ~cs, 4'h1}, {4'h5, cs, 4'h1}};
        for (int i = 0; i < 2; i++) begin
            eep_master_inst.start();
            eep_master_inst.xfer(bad[i], q);
            eep_master_inst.stop();
            chk("addr_miss", {7'h00, q[0]}, 8'h01);
        end
    endtask
    initial begin
        repeat (10) @(negedge i_clk);
        rst = 1'b0;
        repeat (20) @(negedge i_clk);
        t_write_poll();
        t_seq_read();
        t_random();
        t_protect();
        t_reject();
        close_out();
    end
    initial begin
        repeat (100000) @(negedge i_clk);
        n_mismatch++;
        close_out();
    end
endmodule
